// >>> clr_params.svh
// constants for the cache, logic, rotate and return instruction slice
// assumes 32-bit apb data and a 16-bit instruction stream
`ifndef CLR_PARAMS_SVH
`define CLR_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CLR_ADDR_CTRL 12'h000
`define CLR_ADDR_STAT 12'h004
`define CLR_ADDR_SSTAT 12'h008
`define CLR_ADDR_SRET 12'h00C
`define CLR_ADDR_GBP 12'h010
`define CLR_ADDR_PC 12'h014
`define CLR_ADDR_INFO 12'h018
`define CLR_GPR_PAGE 6'h01

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CLR_CTRL_RUN 0
`define CLR_SW_T 0
`define CLR_SW_MD 30
`define CLR_INFO_BUSY 0
`define CLR_INFO_SLOT 1
`define CLR_INFO_EXC 4
`define CLR_SW_RST 32'h4000_0000
`define CLR_PC_RST 32'h0000_0000
`define CLR_PC_STEP 32'h0000_0002
`define CLR_LINE_MASK 32'hFFFF_FFE0

// ----------------------------------------
// execution states per instruction
// ----------------------------------------
`define CLR_ST_ONE 3'h1
`define CLR_ST_OR_MEM 3'h4
`define CLR_ST_RET 3'h5

// ----------------------------------------
// instruction encodings
// ----------------------------------------
`define CLR_ENC_WB 16'b0000_????_1011_0011
`define CLR_ENC_PF 16'b0000_????_1000_0011
`define CLR_ENC_OR_RR 16'b0010_????_????_1011
`define CLR_ENC_OR_I 16'b1100_1011_????_????
`define CLR_ENC_OR_M 16'b1100_1111_????_????
`define CLR_ENC_ROTATE_LEFT_THROUGH_FLAG 16'b0100_????_0010_0100
`define CLR_ENC_ROTATE_RIGHT_THROUGH_FLAG 16'b0100_????_0010_0101
`define CLR_ENC_ROTATE_LEFT_PLAIN 16'b0100_????_0000_0100
`define CLR_ENC_ROTATE_RIGHT_PLAIN 16'b0100_????_0000_0101
`define CLR_ENC_RET 16'b0000_0000_0010_1011
`define CLR_ENC_BRA 16'b101?_????_????_????
`define CLR_ENC_BCOND 16'b1000_1??1_????_????
`define CLR_ENC_BRAF 16'b0000_????_00?0_0011
`define CLR_ENC_JMP 16'b0100_????_00?0_1011
`define CLR_ENC_RTS 16'b0000_0000_0000_1011

`endif

// >>> clr_pkg.sv
// types for the cache, logic, rotate and return instruction slice
// assumes nothing beyond the params header
package clr_pkg;

    typedef enum logic [3:0] {
        OP_NONE, OP_WB, OP_PF, OP_OR_RR, OP_OR_I, OP_OR_M,
        OP_ROTATE_LEFT_THROUGH_FLAG, OP_ROTATE_RIGHT_THROUGH_FLAG, OP_ROTATE_LEFT_PLAIN, OP_ROTATE_RIGHT_PLAIN, OP_RET
    } clr_op_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOOK, ST_FLUSH, ST_FILL, ST_RDB, ST_WRB, ST_EXEC
    } clr_state_t;

    typedef enum logic [2:0] {
        BUS_LOOKUP, BUS_WRBACK, BUS_FILL, BUS_RDB, BUS_WRB
    } clr_bus_cmd_t;

    typedef enum logic [2:0] {
        EXC_NONE, EXC_TLB_MISS, EXC_TLB_PROT, EXC_ADDR_ERR,
        EXC_ILLEGAL, EXC_SLOT_ILLEGAL
    } clr_exc_t;

endpackage : clr_pkg

// >>> clr_decode.sv
// instruction decoder for the slice
// assumes a 16-bit instruction word from the fetch stream
`include "clr_params.svh"

module clr_decode (
    input logic [15:0] i_insn,
    output clr_pkg::clr_op_t o_op,
    output logic o_is_branch
);

    // ----------------------------------------
    // opcode match
    // ----------------------------------------
    always_comb begin
        casez (i_insn)
            `CLR_ENC_WB: o_op = clr_pkg::OP_WB;
            `CLR_ENC_PF: o_op = clr_pkg::OP_PF;
            `CLR_ENC_OR_RR: o_op = clr_pkg::OP_OR_RR;
            `CLR_ENC_OR_I: o_op = clr_pkg::OP_OR_I;
            `CLR_ENC_OR_M: o_op = clr_pkg::OP_OR_M;
            `CLR_ENC_ROTATE_LEFT_THROUGH_FLAG: o_op = clr_pkg::OP_ROTATE_LEFT_THROUGH_FLAG;
            `CLR_ENC_ROTATE_RIGHT_THROUGH_FLAG: o_op = clr_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG;
            `CLR_ENC_ROTATE_LEFT_PLAIN: o_op = clr_pkg::OP_ROTATE_LEFT_PLAIN;
            `CLR_ENC_ROTATE_RIGHT_PLAIN: o_op = clr_pkg::OP_ROTATE_RIGHT_PLAIN;
            `CLR_ENC_RET: o_op = clr_pkg::OP_RET;
            default: o_op = clr_pkg::OP_NONE;
        endcase
    end

    // ----------------------------------------
    // any branch, for delay slot checks
    // ----------------------------------------
    always_comb begin
        casez (i_insn)
            `CLR_ENC_BRA, `CLR_ENC_BCOND, `CLR_ENC_BRAF,
            `CLR_ENC_JMP, `CLR_ENC_RTS, `CLR_ENC_RET: o_is_branch = 1'b1;
            default: o_is_branch = 1'b0;
        endcase
    end

endmodule : clr_decode

// >>> clr_alu.sv
// or and single-bit rotate datapath
// assumes the caller picks the source register
module clr_alu #(
    parameter int WIDTH = 32
) (
    input clr_pkg::clr_op_t i_op,
    input logic [WIDTH-1:0] i_rn,
    input logic [WIDTH-1:0] i_rm,
    input logic [7:0] i_imm,
    input logic i_t,
    output logic [WIDTH-1:0] o_res,
    output logic o_t
);

    // ----------------------------------------
    // result and flag
    // ----------------------------------------
    always_comb begin
        o_res = i_rn;
        o_t = i_t;
        unique case (i_op)
            clr_pkg::OP_OR_RR: o_res = i_rn | i_rm;
            clr_pkg::OP_OR_I: o_res = i_rn | {{(WIDTH-8){1'b0}}, i_imm};
            clr_pkg::OP_ROTATE_LEFT_THROUGH_FLAG: begin
                o_res = {i_rn[WIDTH-2:0], i_t};
                o_t = i_rn[WIDTH-1];
            end
            clr_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG: begin
                o_res = {i_t, i_rn[WIDTH-1:1]};
                o_t = i_rn[0];
            end
            clr_pkg::OP_ROTATE_LEFT_PLAIN: begin
                o_res = {i_rn[WIDTH-2:0], i_rn[WIDTH-1]};
                o_t = i_rn[WIDTH-1];
            end
            clr_pkg::OP_ROTATE_RIGHT_PLAIN: begin
                o_res = {i_rn[0], i_rn[WIDTH-1:1]};
                o_t = i_rn[0];
            end
            default: ;
        endcase
    end

endmodule : clr_alu

// >>> clr_core.sv
// execute unit for the cache hint, or, rotate and return slice
// assumes fetch, operand cache and memory share i_sys_clk; apb slave
`include "clr_params.svh"

module clr_core (
    input logic i_sys_clk,
    input logic i_reset,
    input logic i_psel,
    input logic i_penable,
    input logic i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input logic i_insn_valid,
    input logic [15:0] i_insn,
    input logic i_insn_slot,
    output logic o_insn_ready,
    output logic [31:0] o_fetch_pc,
    output logic o_fetch_priv,
    output logic o_retire,
    output logic o_foreign,
    input logic i_irq_req,
    output logic o_irq_ack,
    output logic o_exc_valid,
    output clr_pkg::clr_exc_t o_exc_code,
    output logic o_bus_req,
    output clr_pkg::clr_bus_cmd_t o_bus_cmd,
    output logic [31:0] o_bus_addr,
    output logic [7:0] o_bus_wdata,
    input logic i_bus_ack,
    input logic [7:0] i_bus_rdata,
    input logic i_bus_hit,
    input logic i_bus_dirty,
    input logic i_bus_cacheable,
    input logic i_bus_tlb_miss,
    input logic i_bus_tlb_prot,
    input logic i_bus_addr_err
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] gpr_q [0:15];
    logic [31:0] sw_q;
    logic [31:0] ssw_q;
    logic [31:0] sret_q;
    logic [31:0] gbp_q;
    logic [31:0] pc_q;
    logic [31:0] target_q;
    logic [31:0] prdata_q;
    logic run_q;
    logic slot_pend_q;
    logic fetch_md_q;
    logic retire_q;
    logic foreign_q;
    logic irq_ack_q;
    logic exc_valid_q;
    clr_pkg::clr_exc_t exc_code_q;
    clr_pkg::clr_exc_t exc_q;
    clr_pkg::clr_state_t state_q;
    clr_pkg::clr_op_t op_q;
    clr_pkg::clr_bus_cmd_t cmd_q;
    logic [2:0] cnt_q;
    logic [15:0] ir_q;
    logic [31:0] baddr_q;
    logic [7:0] bdata_q;

    clr_pkg::clr_op_t dec_op;
    clr_pkg::clr_exc_t acc_exc;
    clr_pkg::clr_exc_t bus_fault;
    logic dec_branch;
    logic take;
    logic irq_take;
    logic fin;
    logic commit;
    logic alu_op;
    logic [31:0] alu_res;
    logic alu_t;
    logic [3:0] dest;
    logic apb_wr;
    logic [31:0] info;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a[11:6] == `CLR_GPR_PAGE) || (a inside {`CLR_ADDR_CTRL, `CLR_ADDR_STAT,
            `CLR_ADDR_SSTAT, `CLR_ADDR_SRET, `CLR_ADDR_GBP, `CLR_ADDR_PC, `CLR_ADDR_INFO});
    endfunction : reg_hit

    function automatic clr_pkg::clr_exc_t fault_of(input logic ae, input logic tm,
                                                    input logic tp);
        if (ae) begin
            fault_of = clr_pkg::EXC_ADDR_ERR;
        end else if (tm) begin
            fault_of = clr_pkg::EXC_TLB_MISS;
        end else if (tp) begin
            fault_of = clr_pkg::EXC_TLB_PROT;
        end else begin
            fault_of = clr_pkg::EXC_NONE;
        end
    endfunction : fault_of

    function automatic logic [2:0] states_of(input clr_pkg::clr_op_t op);
        if (op == clr_pkg::OP_OR_M) begin
            states_of = `CLR_ST_OR_MEM;
        end else if (op == clr_pkg::OP_RET) begin
            states_of = `CLR_ST_RET;
        end else begin
            states_of = `CLR_ST_ONE;
        end
    endfunction : states_of

    // ----------------------------------------
    // decode and datapath
    // ----------------------------------------
    clr_decode u_decode (
        .i_insn(i_insn),
        .o_op(dec_op),
        .o_is_branch(dec_branch)
    );

    assign alu_op = op_q inside {clr_pkg::OP_OR_RR, clr_pkg::OP_OR_I, clr_pkg::OP_ROTATE_LEFT_THROUGH_FLAG,
        clr_pkg::OP_ROTATE_RIGHT_THROUGH_FLAG, clr_pkg::OP_ROTATE_LEFT_PLAIN, clr_pkg::OP_ROTATE_RIGHT_PLAIN};
    assign dest = (op_q == clr_pkg::OP_OR_I) ? 4'h0 : ir_q[11:8];

    clr_alu #(
        .WIDTH(32)
    ) u_alu (
        .i_op(op_q),
        .i_rn(gpr_q[dest]),
        .i_rm(gpr_q[ir_q[7:4]]),
        .i_imm(ir_q[7:0]),
        .i_t(sw_q[`CLR_SW_T]),
        .o_res(alu_res),
        .o_t(alu_t)
    );

    // ----------------------------------------
    // issue control
    // ----------------------------------------
    assign irq_take = i_irq_req && run_q && (state_q == clr_pkg::ST_IDLE) &&
        !slot_pend_q;
    assign o_insn_ready = run_q && (state_q == clr_pkg::ST_IDLE) && !irq_take;
    assign take = i_insn_valid && o_insn_ready;
    assign fin = (state_q == clr_pkg::ST_EXEC) && (cnt_q == `CLR_ST_ONE);
    assign commit = fin && (exc_q == clr_pkg::EXC_NONE);
    assign bus_fault = fault_of(i_bus_addr_err, i_bus_tlb_miss, i_bus_tlb_prot);

    always_comb begin
        if (dec_op == clr_pkg::OP_RET && (i_insn_slot || slot_pend_q)) begin
            acc_exc = clr_pkg::EXC_SLOT_ILLEGAL;
        end else if (slot_pend_q && dec_branch) begin
            acc_exc = clr_pkg::EXC_SLOT_ILLEGAL;
        end else if (dec_op == clr_pkg::OP_RET && !sw_q[`CLR_SW_MD]) begin
            acc_exc = clr_pkg::EXC_ILLEGAL;
        end else begin
            acc_exc = clr_pkg::EXC_NONE;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_q <= clr_pkg::ST_IDLE;
            op_q <= clr_pkg::OP_NONE;
            exc_q <= clr_pkg::EXC_NONE;
            cnt_q <= `CLR_ST_ONE;
            ir_q <= 16'h0000;
        end else begin
            if (state_q != clr_pkg::ST_IDLE && cnt_q > `CLR_ST_ONE) begin
                cnt_q <= cnt_q - `CLR_ST_ONE;
            end
            unique case (state_q)
                clr_pkg::ST_IDLE: begin
                    if (take) begin
                        ir_q <= i_insn;
                        op_q <= dec_op;
                        exc_q <= acc_exc;
                        if (acc_exc != clr_pkg::EXC_NONE) begin
                            cnt_q <= `CLR_ST_ONE;
                            state_q <= clr_pkg::ST_EXEC;
                        end else begin
                            cnt_q <= states_of(dec_op);
                            unique case (dec_op)
                                clr_pkg::OP_WB: state_q <= clr_pkg::ST_LOOK;
                                clr_pkg::OP_PF: state_q <= clr_pkg::ST_FILL;
                                clr_pkg::OP_OR_M: state_q <= clr_pkg::ST_RDB;
                                default: state_q <= clr_pkg::ST_EXEC;
                            endcase
                        end
                    end
                end
                clr_pkg::ST_LOOK: begin
                    if (i_bus_ack) begin
                        exc_q <= bus_fault;
                        state_q <= clr_pkg::ST_EXEC;
                        if (bus_fault == clr_pkg::EXC_NONE && i_bus_hit && i_bus_dirty &&
                            i_bus_cacheable) begin
                            state_q <= clr_pkg::ST_FLUSH;
                        end
                    end
                end
                clr_pkg::ST_RDB, clr_pkg::ST_WRB: begin
                    if (i_bus_ack) begin
                        exc_q <= bus_fault;
                        state_q <= (bus_fault == clr_pkg::EXC_NONE &&
                            state_q == clr_pkg::ST_RDB) ? clr_pkg::ST_WRB :
                            clr_pkg::ST_EXEC;
                    end
                end
                clr_pkg::ST_FLUSH, clr_pkg::ST_FILL: begin
                    if (i_bus_ack) begin
                        state_q <= clr_pkg::ST_EXEC;
                    end
                end
                clr_pkg::ST_EXEC: begin
                    if (cnt_q == `CLR_ST_ONE) begin
                        state_q <= clr_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // cache and memory request
    // ----------------------------------------
    assign o_bus_req = !(state_q inside {clr_pkg::ST_IDLE, clr_pkg::ST_EXEC});

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cmd_q <= clr_pkg::BUS_LOOKUP;
            baddr_q <= 32'h0000_0000;
            bdata_q <= 8'h00;
        end else if (take && state_q == clr_pkg::ST_IDLE) begin
            if (dec_op == clr_pkg::OP_PF) begin
                cmd_q <= clr_pkg::BUS_FILL;
                baddr_q <= gpr_q[i_insn[11:8]] & `CLR_LINE_MASK;
            end else if (dec_op == clr_pkg::OP_OR_M) begin
                cmd_q <= clr_pkg::BUS_RDB;
                baddr_q <= gbp_q + gpr_q[0];
            end else begin
                cmd_q <= clr_pkg::BUS_LOOKUP;
                baddr_q <= gpr_q[i_insn[11:8]];
            end
        end else if (state_q == clr_pkg::ST_LOOK && i_bus_ack) begin
            cmd_q <= clr_pkg::BUS_WRBACK;
        end else if (state_q == clr_pkg::ST_RDB && i_bus_ack) begin
            cmd_q <= clr_pkg::BUS_WRB;
            bdata_q <= i_bus_rdata | ir_q[7:0];
        end
    end

    assign o_bus_cmd = cmd_q;
    assign o_bus_addr = baddr_q;
    assign o_bus_wdata = bdata_q;

    // ----------------------------------------
    // general registers
    // ----------------------------------------
    assign apb_wr = i_psel && i_penable && i_pwrite;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            for (int i = 0; i < 16; i++) begin
                gpr_q[i] <= 32'h0000_0000;
            end
        end else if (apb_wr && i_paddr[11:6] == `CLR_GPR_PAGE && i_paddr[1:0] == 2'h0) begin
            gpr_q[i_paddr[5:2]] <= i_pwdata;
        end else if (commit && alu_op) begin
            gpr_q[dest] <= alu_res;
        end
    end

    // ----------------------------------------
    // status word, pc and return state
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sw_q <= `CLR_SW_RST;
        end else if (apb_wr && i_paddr == `CLR_ADDR_STAT) begin
            sw_q <= i_pwdata;
        end else if (commit && op_q == clr_pkg::OP_RET) begin
            sw_q <= ssw_q;
        end else if (commit && alu_op) begin
            sw_q[`CLR_SW_T] <= alu_t;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ssw_q <= 32'h0000_0000;
            sret_q <= 32'h0000_0000;
            gbp_q <= 32'h0000_0000;
            run_q <= 1'b0;
        end else if (apb_wr) begin
            if (i_paddr == `CLR_ADDR_SSTAT) begin
                ssw_q <= i_pwdata;
            end
            if (i_paddr == `CLR_ADDR_SRET) begin
                sret_q <= i_pwdata;
            end
            if (i_paddr == `CLR_ADDR_GBP) begin
                gbp_q <= i_pwdata;
            end
            if (i_paddr == `CLR_ADDR_CTRL) begin
                run_q <= i_pwdata[`CLR_CTRL_RUN];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            target_q <= 32'h0000_0000;
        end else if (take && dec_op == clr_pkg::OP_RET && acc_exc == clr_pkg::EXC_NONE) begin
            target_q <= sret_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            pc_q <= `CLR_PC_RST;
        end else if (apb_wr && i_paddr == `CLR_ADDR_PC) begin
            pc_q <= i_pwdata;
        end else if (commit && op_q != clr_pkg::OP_RET && slot_pend_q) begin
            pc_q <= target_q;
        end else if (commit) begin
            pc_q <= pc_q + `CLR_PC_STEP;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            slot_pend_q <= 1'b0;
        end else if (fin) begin
            slot_pend_q <= commit && op_q == clr_pkg::OP_RET;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            fetch_md_q <= 1'(`CLR_SW_RST >> `CLR_SW_MD);
        end else if (!slot_pend_q && !(state_q != clr_pkg::ST_IDLE &&
                     op_q == clr_pkg::OP_RET)) begin
            fetch_md_q <= sw_q[`CLR_SW_MD];
        end
    end

    assign o_fetch_pc = pc_q;
    assign o_fetch_priv = fetch_md_q;

    // ----------------------------------------
    // completion pulses
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            retire_q <= 1'b0;
            foreign_q <= 1'b0;
            irq_ack_q <= 1'b0;
            exc_valid_q <= 1'b0;
            exc_code_q <= clr_pkg::EXC_NONE;
        end else begin
            retire_q <= commit;
            foreign_q <= commit && op_q == clr_pkg::OP_NONE;
            irq_ack_q <= irq_take;
            exc_valid_q <= fin && exc_q != clr_pkg::EXC_NONE;
            if (fin) begin
                exc_code_q <= exc_q;
            end
        end
    end

    assign o_retire = retire_q;
    assign o_foreign = foreign_q;
    assign o_irq_ack = irq_ack_q;
    assign o_exc_valid = exc_valid_q;
    assign o_exc_code = exc_code_q;

    // ----------------------------------------
    // apb read
    // ----------------------------------------
    always_comb begin
        info = 32'h0000_0000;
        info[`CLR_INFO_BUSY] = state_q != clr_pkg::ST_IDLE;
        info[`CLR_INFO_SLOT] = slot_pend_q;
        info[`CLR_INFO_EXC +: 3] = exc_code_q;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prdata_q <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            if (i_paddr[11:6] == `CLR_GPR_PAGE) begin
                prdata_q <= gpr_q[i_paddr[5:2]];
            end else begin
                unique case (i_paddr)
                    `CLR_ADDR_CTRL: prdata_q <= {31'h0000_0000, run_q};
                    `CLR_ADDR_STAT: prdata_q <= sw_q;
                    `CLR_ADDR_SSTAT: prdata_q <= ssw_q;
                    `CLR_ADDR_SRET: prdata_q <= sret_q;
                    `CLR_ADDR_GBP: prdata_q <= gbp_q;
                    `CLR_ADDR_PC: prdata_q <= pc_q;
                    `CLR_ADDR_INFO: prdata_q <= info;
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && (!reg_hit(i_paddr) || i_paddr[1:0] != 2'h0);

endmodule : clr_core

// >>> clr_core_monitor.sv
// checker on the instruction and bus ports of clr_core
// assumes it is bound onto clr_core
`include "clr_params.svh"
module clr_core_monitor (
    input wire logic i_sys_clk, i_reset, i_insn_valid, i_insn_slot, o_insn_ready, o_retire,
    input wire logic o_foreign, o_fetch_priv, o_exc_valid, o_bus_req, i_bus_ack,
    input wire logic i_bus_hit, i_bus_dirty, i_bus_cacheable, i_bus_tlb_miss,
    input wire logic [15:0] i_insn,
    input wire logic [31:0] o_fetch_pc, o_bus_addr,
    input wire clr_pkg::clr_exc_t o_exc_code,
    input wire clr_pkg::clr_bus_cmd_t o_bus_cmd
);
    // ----
    // properties
    // ----
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    wire tk = i_insn_valid && o_insn_ready;
    wire ret = tk && i_insn == `CLR_ENC_RET;
    wire ak = o_bus_req && i_bus_ack;
    sequence lk; ak && o_bus_cmd == clr_pkg::BUS_LOOKUP; endsequence
    sequence wr; o_bus_req && o_bus_cmd == clr_pkg::BUS_WRB; endsequence
    line_align_a: assert property (o_bus_req && o_bus_cmd == clr_pkg::BUS_FILL
        |-> o_bus_addr[4:0] == 5'h00) else $error("fill unaligned");
    clean_skip_a: assert property (lk ##0 !(i_bus_hit && i_bus_dirty && i_bus_cacheable)
        |=> !(o_bus_req && o_bus_cmd == clr_pkg::BUS_WRBACK) [*2]) else $error("writeback");
    fault_raise_a: assert property (lk ##0 i_bus_tlb_miss
        |-> ##[1:3] o_exc_valid && o_exc_code == clr_pkg::EXC_TLB_MISS) else $error("no fault");
    byte_order_a: assert property (ak && o_bus_cmd == clr_pkg::BUS_RDB && !i_bus_tlb_miss
        |=> ##[0:2] wr) else $error("no byte write");
    fill_quiet_a: assert property (ak && o_bus_cmd == clr_pkg::BUS_FILL
        |=> !o_exc_valid [*2]) else $error("fill fault");
    or_single_a: assert property (tk && i_insn ==? `CLR_ENC_OR_RR
        |-> ##2 o_retire && !o_foreign) else $error("or timing");
    rot_step_a: assert property (tk && i_insn ==? `CLR_ENC_ROTATE_LEFT_PLAIN
        |-> ##2 o_retire && o_fetch_pc == $past(o_fetch_pc, 2) + 32'h2) else $error("pc step");
    ret_user_a: assert property (ret && !o_fetch_priv && !i_insn_slot
        |-> ##[1:7] o_exc_valid && o_exc_code == clr_pkg::EXC_ILLEGAL) else $error("user ret");
    ret_five_a: assert property (ret && o_fetch_priv && !i_insn_slot
        |-> ##6 o_retire) else $error("ret states");
    slot_ret_a: assert property (ret && i_insn_slot
        |-> ##[1:7] o_exc_valid && o_exc_code == clr_pkg::EXC_SLOT_ILLEGAL) else $error("slot");
endmodule : clr_core_monitor

bind clr_core clr_core_monitor mon_u (.*);

// >>> clr_bus_model.sv
// operand cache and memory partner, acking one cycle after each request
// assumes the bench sets dirty and fault between instructions
module clr_bus_model (
    input wire logic i_sys_clk, o_bus_req, dirty, fault,
    input wire clr_pkg::clr_bus_cmd_t o_bus_cmd,
    input wire logic [31:0] o_bus_addr,
    input wire logic [7:0] o_bus_wdata,
    output logic i_bus_ack = 0, i_bus_hit = 0, i_bus_dirty = 0, i_bus_cacheable = 0,
    output logic i_bus_tlb_miss = 0, i_bus_tlb_prot = 0, i_bus_addr_err = 0,
    output logic [7:0] i_bus_rdata = 0
);
    int wcnt = 0;
    logic [31:0] waddr, faddr;
    logic [7:0] wbyte;
    always @(posedge i_sys_clk) begin
        i_bus_ack <= o_bus_req && !i_bus_ack;
        i_bus_rdata <= (o_bus_req && !i_bus_ack) ? 8'hA5 : ~i_bus_rdata;
        {i_bus_hit, i_bus_dirty, i_bus_cacheable, i_bus_tlb_miss} <= {1'b1, dirty, 1'b1, fault};
        if (o_bus_req && i_bus_ack) begin
            if (o_bus_cmd == clr_pkg::BUS_WRBACK) wcnt <= wcnt + 1;
            if (o_bus_cmd == clr_pkg::BUS_WRB) {waddr, wbyte} <= {o_bus_addr, o_bus_wdata};
            if (o_bus_cmd == clr_pkg::BUS_FILL) faddr <= o_bus_addr;
        end
    end
endmodule : clr_bus_model

// >>> cache_logic_rotate_return_ops_bench.sv
// bench for clr_core over apb and the instruction port
// assumes clr_bus_model answers the cache bus
`include "clr_params.svh"
module cache_logic_rotate_return_ops_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_irq_req = 0;
    logic i_insn_valid = 0, i_insn_slot = 0, dirty = 0, fault = 0, ex, t, et, se;
    logic [11:0] i_paddr = 0;
    logic [15:0] i_insn = 0;
    logic [31:0] i_pwdata = 0, o_prdata, o_fetch_pc, o_bus_addr, rd, v, e;
    logic [7:0] o_bus_wdata, i_bus_rdata;
    logic o_pready, o_pslverr, o_insn_ready, o_fetch_priv, o_retire, o_foreign, o_irq_ack;
    logic o_exc_valid, o_bus_req, i_bus_ack, i_bus_hit, i_bus_dirty, i_bus_cacheable;
    logic i_bus_tlb_miss, i_bus_tlb_prot, i_bus_addr_err;
    clr_pkg::clr_exc_t o_exc_code;
    clr_pkg::clr_bus_cmd_t o_bus_cmd;
    int bad_count = 0, comparisons = 0;
`define CHK(n, x, s) begin comparisons++; if ((s) !== (x)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, x, s); end end
    always #25 i_sys_clk = ~i_sys_clk;
    clr_core dut_u (.*);
    clr_bus_model bus_u (.*);
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_sys_clk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_sys_clk) i_penable <= 1;
        do @(posedge i_sys_clk); while (o_pready !== 1'b1);
        {se, rd} = {o_pslverr, o_prdata};
        {i_psel, i_penable} <= 2'h0;
    endtask : apb
    task ins(input logic [15:0] c, input logic s);
        @(posedge i_sys_clk) {i_insn_valid, i_insn, i_insn_slot} <= {1'b1, c, s};
        do @(negedge i_sys_clk); while (o_insn_ready !== 1'b1);
        @(posedge i_sys_clk) i_insn_valid <= 0;
        ex = 0;
        repeat (20) if (!ex && o_retire !== 1'b1) @(negedge i_sys_clk) ex = o_exc_valid;
    endtask : ins
    task end_sim;
        $display("compared %0d, mismatched %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        #500000 bad_count++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset <= 0;
        apb(0, `CLR_ADDR_STAT, 0); `CHK("status", `CLR_SW_RST, rd)
        apb(0, 12'h03C, 0); `CHK("unmapped", 33'h1_0000_0000, {se, rd})
        apb(1, `CLR_ADDR_CTRL, 1);
        for (int j = 0; j < 8; j++) begin
            v = j[2] ? 32'h80000001 : 32'h00000002;
            t = !j[2];
            apb(1, 12'h044, v);
            apb(1, `CLR_ADDR_STAT, {2'h1, 29'h0, t});
            ins(16'h4104 | 16'(j[0]) | (16'(j[1]) << 5), 0);
            case (j[1:0])
                2'h0: {e, et} = {v[30:0], v[31], v[31]};
                2'h1: {e, et} = {v[0], v[31:1], v[0]};
                2'h2: {e, et} = {v[30:0], t, v[31]};
                default: {e, et} = {t, v[31:1], v[0]};
            endcase
            apb(0, 12'h044, 0); `CHK("rot reg", e, rd)
            apb(0, `CLR_ADDR_STAT, 0); `CHK("rot t", et, rd[0])
        end
        $display("rotate test done");
        apb(1, 12'h040, 32'hAAAA5555);
        apb(1, 12'h044, 32'h55550000);
        ins(16'h210B, 0);
        apb(0, 12'h044, 0); `CHK("or rr", 32'hFFFF5555, rd)
        apb(0, `CLR_ADDR_STAT, 0); `CHK("or t", et, rd[0])
        apb(1, 12'h040, 32'h8);
        ins(16'hCBF0, 0);
        apb(0, 12'h040, 0); `CHK("or imm", 32'hF8, rd)
        apb(1, `CLR_ADDR_GBP, 32'h100);
        apb(1, 12'h040, 32'h20);
        ins(16'hCF50, 0); `CHK("or byte", {32'h120, 8'hF5}, {bus_u.waddr, bus_u.wbyte})
        $display("or test done");
        apb(1, 12'h048, 32'h1234567F);
        fault <= 1;
        ins(16'h0283, 0); `CHK("fill", {32'h12345660, 1'b0}, {bus_u.faddr, ex})
        {fault, dirty} <= 2'h1;
        ins(16'h02B3, 0); `CHK("wb dirty", 1, bus_u.wcnt)
        dirty <= 0;
        ins(16'h02B3, 0); `CHK("wb clean", 1, bus_u.wcnt)
        {fault, dirty} <= 2'h3;
        ins(16'h02B3, 0); `CHK("wb fault", clr_pkg::EXC_TLB_MISS, o_exc_code)
        fault <= 0;
        $display("cache test done");
        apb(1, `CLR_ADDR_SSTAT, 32'h1);
        apb(1, `CLR_ADDR_SRET, 32'h200);
        ins(`CLR_ENC_RET, 0); `CHK("old priv", 1'b1, o_fetch_priv)
        ins(16'h0009, 0);
        apb(0, `CLR_ADDR_STAT, 0); `CHK("restored", 32'h1, rd)
        apb(0, `CLR_ADDR_PC, 0); `CHK("target", 32'h200, rd)
        ins(`CLR_ENC_RET, 0); `CHK("user ret", clr_pkg::EXC_ILLEGAL, o_exc_code)
        apb(1, `CLR_ADDR_STAT, `CLR_SW_RST);
        ins(`CLR_ENC_RET, 1); `CHK("ret slot", clr_pkg::EXC_SLOT_ILLEGAL, o_exc_code)
        ins(`CLR_ENC_RET, 0);
        ins(16'hA000, 0); `CHK("br slot", clr_pkg::EXC_SLOT_ILLEGAL, o_exc_code)
        $display("return test done");
        end_sim();
    end
endmodule : cache_logic_rotate_return_ops_bench
